// *** pkg/efps_pkg.sv ***
package efps_pkg;

    // register map: selection register and a read-only status word
    localparam logic [31:0] EFPS_SEL_ADDR   = 32'hE002C014;
    localparam logic [31:0] EFPS_STAT_ADDR  = 32'hE002C0FC;

    // bit positions inside the selection register
    localparam int unsigned EFPS_B_DEBUG    = 2;
    localparam int unsigned EFPS_B_TRACE    = 3;
    localparam int unsigned EFPS_B_BUS      = 4;
    localparam int unsigned EFPS_B_ANALOG_INPUT_6     = 6;
    localparam int unsigned EFPS_B_ANALOG_INPUT_7     = 7;
    localparam int unsigned EFPS_B_WE       = 8;
    localparam int unsigned EFPS_B_CS1      = 11;
    localparam int unsigned EFPS_B_EXTERNAL_CLOCK_OUTPUT     = 13;
    localparam int unsigned EFPS_B_CS2      = 14;
    localparam int unsigned EFPS_B_CS3      = 16;
    localparam int unsigned EFPS_B_P2RSV    = 20;
    localparam int unsigned EFPS_B_ANALOG_INPUT_4     = 21;
    localparam int unsigned EFPS_B_ANALOG_INPUT_5     = 22;
    localparam int unsigned EFPS_B_A0       = 23;
    localparam int unsigned EFPS_B_A1       = 24;
    localparam int unsigned EFPS_B_ACNT     = 25;

    // writable bits, fixed part of the reset value
    localparam logic [31:0] EFPS_WR_MASK    = 32'h0FF3E9FC;
    localparam logic [31:0] EFPS_RST_FIXED  = 32'h006000C0;

    // bus field codes
    localparam logic [1:0]  EFPS_BUS_8      = 2'h0;
    localparam logic [1:0]  EFPS_BUS_16     = 2'h1;
    localparam logic [1:0]  EFPS_BUS_32     = 2'h2;
    localparam logic [1:0]  EFPS_BUS_OFF    = 2'h3;
    // chip select field code, address count codes
    localparam logic [1:0]  EFPS_CS_ON      = 2'h1;
    localparam logic [2:0]  EFPS_ACNT_NONE  = 3'h0;
    localparam logic [2:0]  EFPS_ACNT_ALL   = 3'h7;
    // boot pin patterns that alter reset values
    localparam logic [1:0]  EFPS_BOOT_A0    = 2'h0;
    localparam logic [1:0]  EFPS_BOOT_NOADR = 2'h3;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } efps_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } efps_apb_rsp_s;

    // one enable per alternate role; zero means the pin stays a port pin
    typedef struct packed {
        logic        debug_port;
        logic        trace_port;
        logic        data_lane_7_0;
        logic        chip_select_0;
        logic        output_enable;
        logic        byte_lane_strobe_0;
        logic        data_lane_15_8;
        logic        byte_lane_strobe_1;
        logic        data_lane_31_16;
        logic        byte_lane_strobe_2_3;
        logic        analog_input_4;
        logic        analog_input_5;
        logic        analog_input_6;
        logic        analog_input_7;
        logic        write_enable;
        logic        chip_select_1;
        logic        chip_select_2;
        logic        chip_select_3;
        logic        external_clock_output;
        logic        address_line_0;
        logic        address_line_1;
        logic [21:0] address_line_23_2;
    } efps_role_s;

    // address lines A23..A2 enabled by the count field
    function automatic logic [21:0] efps_addr_mask(input logic [2:0] cnt);
        logic [21:0] m;
        m = 22'h0;
        unique case (cnt)
            3'h0: m = 22'h000000;
            3'h1: m = 22'h000003;
            3'h2: m = 22'h00000F;
            3'h3: m = 22'h00003F;
            3'h4: m = 22'h0003FF;
            3'h5: m = 22'h003FFF;
            3'h6: m = 22'h03FFFF;
            3'h7: m = 22'h3FFFFF;
        endcase
        return m;
    endfunction : efps_addr_mask

    // expand apb byte strobes to a bit mask
    function automatic logic [31:0] efps_byte_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : efps_byte_mask

endpackage : efps_pkg

// *** core/efps_pin_select.sv ***
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps

// Behaviour
// - bit 2 set routes port-1 pins 31..26 to the debug port.
// - bit 3 set routes port-1 pins 25..16 to the trace port.
// - bus field 00/01/10 enables data 7..0, select 0, output enable, strobe 0.
// - bus field 01 or 10 also enables data 15..8 and strobe 1.
// - only bus field 10 enables data 31..16 on port-2 pins 31..16.
// - only bus field 10 turns port-3 pins 29,28 into strobes 2 and 3.
// - outside 32-bit mode bit 6 picks analogue input 6 over pin 3.29.
// - outside 32-bit mode bit 7 picks analogue input 7 over pin 3.28.
// - outside 32-bit mode bit 20 keeps port-2 pins 29,28 as port pins; one is reserved.
// - outside 32-bit mode bit 21 picks analogue input 4; resets to one.
// - outside 32-bit mode bit 22 picks analogue input 5; resets to one.
// - bit 8 gives pin 3.27 to the write strobe; resets to zero.
// - bit 11 gives pin 3.26 to chip select 1; resets to zero.
// - field 15:14 value 01 selects chip select 2; other nonzero reserved.
// - field 17:16 value 01 selects chip select 3; other nonzero reserved.
// - bit 23 selects address line 0; resets one only for boot pins 00.
// - bit 24 selects address line 1; resets to upper boot pin.
// - count field sets address lines down to A2; resets 000 for boot 11.
module efps_pin_select (
    // clock, reset, enable
    input  wire  logic                   MCLK,
    input  wire  logic                   SRST,
    input  wire  logic                   CE,
    // apb register port
    input  wire  efps_pkg::efps_apb_req_s APB_REQ,
    output       efps_pkg::efps_apb_rsp_s APB_RSP,
    // boot strap pins
    input  wire  logic [1:0]             BOOT_SELECT_PINS,
    // pin role enables to the pin multiplexers
    output       efps_pkg::efps_role_s   PIN_ROLE
);
    import efps_pkg::*;

    typedef struct packed {
        logic [1:0]  boot_sync1;
        logic [1:0]  boot_sync2;
        logic [1:0]  boot_latched;
        logic [31:0] sel;
        efps_role_s  role;
        logic [31:0] prdata;
        logic        pslverr;
    } efps_state_s;

    efps_state_s st_r;
    efps_state_s st_nxt;

    // reset image of the selection register from sampled boot pins
    function automatic logic [31:0] sel_reset(input logic [1:0] boot);
        logic [31:0] v;
        v = EFPS_RST_FIXED;
        v[EFPS_B_BUS +: 2]  = boot;
        v[EFPS_B_A0]        = (boot == EFPS_BOOT_A0);
        v[EFPS_B_A1]        = boot[1];
        v[EFPS_B_ACNT +: 3] = (boot == EFPS_BOOT_NOADR) ? EFPS_ACNT_NONE
                                                        : EFPS_ACNT_ALL;
        return v;
    endfunction : sel_reset

    // decode of the selection register into pin roles
    function automatic efps_role_s decode(input logic [31:0] s);
        efps_role_s r;
        logic [1:0] bus;
        logic       wide;
        logic [2:0] acnt;
        bus  = s[EFPS_B_BUS +: 2];
        wide = (bus == EFPS_BUS_32);
        acnt = s[EFPS_B_ACNT +: 3];
        r = '0;
        r.debug_port            = s[EFPS_B_DEBUG];
        r.trace_port            = s[EFPS_B_TRACE];
        r.data_lane_7_0         = (bus != EFPS_BUS_OFF);
        r.chip_select_0         = (bus != EFPS_BUS_OFF);
        r.output_enable         = (bus != EFPS_BUS_OFF);
        r.byte_lane_strobe_0    = (bus != EFPS_BUS_OFF);
        r.data_lane_15_8        = (bus == EFPS_BUS_16) || wide;
        r.byte_lane_strobe_1    = (bus == EFPS_BUS_16) || wide;
        // bit 20 only ever leaves pins 29:28 as port pins
        r.data_lane_31_16       = wide;
        r.byte_lane_strobe_2_3  = wide;
        r.analog_input_6        = !wide && s[EFPS_B_ANALOG_INPUT_6];
        r.analog_input_7        = !wide && s[EFPS_B_ANALOG_INPUT_7];
        r.analog_input_4        = !wide && s[EFPS_B_ANALOG_INPUT_4];
        r.analog_input_5        = !wide && s[EFPS_B_ANALOG_INPUT_5];
        r.write_enable          = s[EFPS_B_WE];
        r.chip_select_1         = s[EFPS_B_CS1];
        r.external_clock_output = (acnt != EFPS_ACNT_ALL) && s[EFPS_B_EXTERNAL_CLOCK_OUTPUT];
        r.chip_select_2         = (s[EFPS_B_CS2 +: 2] == EFPS_CS_ON);
        r.chip_select_3         = (s[EFPS_B_CS3 +: 2] == EFPS_CS_ON);
        r.address_line_0        = s[EFPS_B_A0];
        r.address_line_1        = s[EFPS_B_A1];
        r.address_line_23_2     = efps_addr_mask(acnt);
        return r;
    endfunction : decode

    // apb phase and address decode
    logic setup_ph;
    logic access_ph;
    logic hit_sel;
    logic hit_stat;
    logic rsv_used;

    assign setup_ph  = APB_REQ.psel && !APB_REQ.penable;
    assign access_ph = APB_REQ.psel && APB_REQ.penable;
    assign hit_sel   = (APB_REQ.paddr == EFPS_SEL_ADDR);
    assign hit_stat  = (APB_REQ.paddr == EFPS_STAT_ADDR);
    // reserved codes written to the chip select fields or bit 20
    assign rsv_used  = st_r.sel[EFPS_B_CS2 + 1] || st_r.sel[EFPS_B_CS3 + 1]
                     || st_r.sel[EFPS_B_P2RSV];

    // next state: boot synchroniser, register, role decode, apb answer
    always_comb begin
        st_nxt = st_r;
        st_nxt.boot_sync1 = BOOT_SELECT_PINS;
        st_nxt.boot_sync2 = st_r.boot_sync1;
        if (SRST) begin
            st_nxt.sel          = sel_reset(st_r.boot_sync2);
            st_nxt.boot_latched = st_r.boot_sync2;
            st_nxt.role         = decode(sel_reset(st_r.boot_sync2));
            st_nxt.prdata       = 32'h0;
            st_nxt.pslverr      = 1'b0;
        end else begin
            st_nxt.role = decode(st_r.sel);
            // answer is prepared in the setup cycle and held through access
            if (setup_ph) begin
                st_nxt.pslverr = !(hit_sel || hit_stat);
                st_nxt.prdata  = 32'h0;
                if (!APB_REQ.pwrite && hit_sel) begin
                    st_nxt.prdata = st_r.sel & EFPS_WR_MASK;
                end else if (!APB_REQ.pwrite && hit_stat) begin
                    st_nxt.prdata = {29'h0, rsv_used, st_r.boot_latched};
                end
            end
            // write lands at the access edge, reserved bits held at zero
            if (access_ph && APB_REQ.pwrite && hit_sel) begin
                st_nxt.sel = (st_r.sel & ~(efps_byte_mask(APB_REQ.pstrb) & EFPS_WR_MASK))
                           | (APB_REQ.pwdata & efps_byte_mask(APB_REQ.pstrb)
                              & EFPS_WR_MASK);
            end
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge MCLK) begin
        if (CE) begin
            st_r <= st_nxt;
        end
    end

    // outputs: zero-wait apb answer and registered roles
    assign APB_RSP.pready  = 1'b1;
    assign APB_RSP.prdata  = st_r.prdata;
    assign APB_RSP.pslverr = st_r.pslverr;
    assign PIN_ROLE        = st_r.role;

    // checks
    logic run;
    assign run = CE && !SRST;

    property p_debug;
        @(posedge MCLK) disable iff (SRST)
        run |=> (PIN_ROLE.debug_port == $past(st_r.sel[EFPS_B_DEBUG]));
    endproperty
    a_debug: assert property (p_debug) else $error("debug role mismatch");

    property p_trace;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_TRACE]) |=> PIN_ROLE.trace_port;
    endproperty
    a_trace: assert property (p_trace) else $error("trace role missing");

    property p_narrow;
        @(posedge MCLK) disable iff (SRST)
        run |=> (PIN_ROLE.data_lane_7_0
                 == ($past(st_r.sel[EFPS_B_BUS +: 2]) != EFPS_BUS_OFF))
                && (PIN_ROLE.chip_select_0 == PIN_ROLE.byte_lane_strobe_0);
    endproperty
    a_narrow: assert property (p_narrow) else $error("low lanes wrong");

    property p_mid;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_BUS +: 2] == EFPS_BUS_16)
            |=> PIN_ROLE.data_lane_15_8 && PIN_ROLE.byte_lane_strobe_1
                && !PIN_ROLE.data_lane_31_16;
    endproperty
    a_mid: assert property (p_mid) else $error("16-bit lanes wrong");

    property p_wide;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_BUS +: 2] == EFPS_BUS_32)
            |=> PIN_ROLE.data_lane_31_16 && PIN_ROLE.byte_lane_strobe_2_3
                && !PIN_ROLE.analog_input_4 && !PIN_ROLE.analog_input_5
                && !PIN_ROLE.analog_input_6 && !PIN_ROLE.analog_input_7;
    endproperty
    a_wide: assert property (p_wide) else $error("32-bit lanes wrong");

    property p_ain;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_BUS +: 2] != EFPS_BUS_32)
            |=> (PIN_ROLE.analog_input_6 == $past(st_r.sel[EFPS_B_ANALOG_INPUT_6]))
                && (PIN_ROLE.analog_input_7 == $past(st_r.sel[EFPS_B_ANALOG_INPUT_7]))
                && (PIN_ROLE.analog_input_4 == $past(st_r.sel[EFPS_B_ANALOG_INPUT_4]))
                && (PIN_ROLE.analog_input_5 == $past(st_r.sel[EFPS_B_ANALOG_INPUT_5]));
    endproperty
    a_ain: assert property (p_ain) else $error("analogue select wrong");

    property p_p2rsv;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_P2RSV] && st_r.sel[EFPS_B_BUS +: 2] != EFPS_BUS_32)
            |=> !PIN_ROLE.data_lane_31_16;
    endproperty
    a_p2rsv: assert property (p_p2rsv) else $error("bit 20 changed lanes");

    property p_strobes;
        @(posedge MCLK) disable iff (SRST)
        run |=> (PIN_ROLE.write_enable == $past(st_r.sel[EFPS_B_WE]))
                && (PIN_ROLE.chip_select_1 == $past(st_r.sel[EFPS_B_CS1]));
    endproperty
    a_strobes: assert property (p_strobes) else $error("we or cs1 wrong");

    property p_external_clock_output;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_ACNT +: 3] == EFPS_ACNT_ALL)
            |=> !PIN_ROLE.external_clock_output && PIN_ROLE.address_line_23_2[21];
    endproperty
    a_external_clock_output: assert property (p_external_clock_output) else $error("clock output over A23");

    property p_cs23;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_CS2 +: 2] != EFPS_CS_ON
             && st_r.sel[EFPS_B_CS3 +: 2] != EFPS_CS_ON)
            |=> !PIN_ROLE.chip_select_2 && !PIN_ROLE.chip_select_3;
    endproperty
    a_cs23: assert property (p_cs23) else $error("cs2/cs3 on bad code");

    property p_boot;
        @(posedge MCLK)
        // only once the synchroniser has filled, so power-up unknowns are not judged
        (SRST && CE && $past(SRST) && $past(SRST, 2))
            |=> (st_r.sel[EFPS_B_BUS +: 2] == $past(st_r.boot_sync2))
            && (st_r.sel[EFPS_B_A0] == ($past(st_r.boot_sync2) == EFPS_BOOT_A0))
            && (st_r.sel[EFPS_B_A1] == $past(st_r.boot_sync2[1]))
            && (st_r.sel[EFPS_B_ANALOG_INPUT_4] && st_r.sel[EFPS_B_ANALOG_INPUT_7] && !st_r.sel[EFPS_B_WE]);
    endproperty
    a_boot: assert property (p_boot) else $error("boot reset value wrong");

    property p_acnt;
        @(posedge MCLK)
        (SRST && CE && st_r.boot_sync2 == EFPS_BOOT_NOADR)
            |=> (st_r.sel[EFPS_B_ACNT +: 3] == EFPS_ACNT_NONE) ##1
                (!CE || PIN_ROLE.address_line_23_2 == 22'h0 || !SRST);
    endproperty
    a_acnt: assert property (p_acnt) else $error("address count reset wrong");

    property p_rsv;
        @(posedge MCLK) disable iff (SRST)
        (run && access_ph && APB_REQ.pwrite && hit_sel)
            |=> ((st_r.sel & ~EFPS_WR_MASK) == 32'h0) ##1
                (!APB_REQ.psel || APB_REQ.pwrite || !hit_sel
                 || ((APB_RSP.prdata & ~EFPS_WR_MASK) == 32'h0));
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit not zero");

    // trace pins fall back to port use when the bit is clear
    property p_trace_off;
        @(posedge MCLK) disable iff (SRST)
        (run && !st_r.sel[EFPS_B_TRACE]) |=> !PIN_ROLE.trace_port;
    endproperty
    a_trace_off: assert property (p_trace_off) else $error("trace role stuck");

    // bus switched off frees every data lane, the output enable and strobes 1 to 3
    property p_bus_off;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_BUS +: 2] == EFPS_BUS_OFF)
            |=> !PIN_ROLE.data_lane_7_0 && !PIN_ROLE.output_enable
                && !PIN_ROLE.data_lane_15_8 && !PIN_ROLE.byte_lane_strobe_1
                && !PIN_ROLE.data_lane_31_16 && !PIN_ROLE.byte_lane_strobe_2_3;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("lanes on with bus off");

    // 8-bit bus keeps the upper lanes as port pins
    property p_bus8;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_BUS +: 2] == EFPS_BUS_8)
            |=> PIN_ROLE.data_lane_7_0 && !PIN_ROLE.data_lane_15_8
                && !PIN_ROLE.byte_lane_strobe_1 && !PIN_ROLE.data_lane_31_16;
    endproperty
    a_bus8: assert property (p_bus8) else $error("8-bit lanes wrong");

    // clock output follows bit 13 while A23 is not claimed
    property p_external_clock_output_on;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_ACNT +: 3] != EFPS_ACNT_ALL)
            |=> (PIN_ROLE.external_clock_output == $past(st_r.sel[EFPS_B_EXTERNAL_CLOCK_OUTPUT]));
    endproperty
    a_external_clock_output_on: assert property (p_external_clock_output_on) else $error("clock output wrong");

    // chip selects 2 and 3 on their enabling code
    property p_cs_on;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_CS2 +: 2] == EFPS_CS_ON
             && st_r.sel[EFPS_B_CS3 +: 2] == EFPS_CS_ON)
            |=> PIN_ROLE.chip_select_2 && PIN_ROLE.chip_select_3;
    endproperty
    a_cs_on: assert property (p_cs_on) else $error("cs2/cs3 missing");

    // low address lines follow their own bits
    property p_a01;
        @(posedge MCLK) disable iff (SRST)
        run |=> (PIN_ROLE.address_line_0 == $past(st_r.sel[EFPS_B_A0]))
                && (PIN_ROLE.address_line_1 == $past(st_r.sel[EFPS_B_A1]));
    endproperty
    a_a01: assert property (p_a01) else $error("A0/A1 role wrong");

    // no address lines when the count field is zero
    property p_acnt_none;
        @(posedge MCLK) disable iff (SRST)
        (run && st_r.sel[EFPS_B_ACNT +: 3] == EFPS_ACNT_NONE)
            |=> (PIN_ROLE.address_line_23_2 == 22'h0);
    endproperty
    a_acnt_none: assert property (p_acnt_none) else $error("address lines on");

    // unmapped place answers with an error and zero data
    property p_unmapped;
        @(posedge MCLK) disable iff (SRST)
        (run && setup_ph && !hit_sel && !hit_stat)
            |=> APB_RSP.pslverr && (APB_RSP.prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped answer wrong");

    // mapped places answer without error
    property p_mapped;
        @(posedge MCLK) disable iff (SRST)
        (run && setup_ph && (hit_sel || hit_stat)) |=> !APB_RSP.pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped place errored");

    // read of the selection register shows only writable bits
    property p_rdsel;
        @(posedge MCLK) disable iff (SRST)
        (run && setup_ph && !APB_REQ.pwrite && hit_sel)
            |=> (APB_RSP.prdata == ($past(st_r.sel) & EFPS_WR_MASK));
    endproperty
    a_rdsel: assert property (p_rdsel) else $error("read data wrong");

    // answer stands until the next setup cycle
    property p_hold;
        @(posedge MCLK) disable iff (SRST)
        (run && !setup_ph) |=> $stable(APB_RSP.prdata) && $stable(APB_RSP.pslverr);
    endproperty
    a_hold: assert property (p_hold) else $error("answer moved early");

    // writes elsewhere leave the selection register alone
    property p_nowrite;
        @(posedge MCLK) disable iff (SRST)
        (run && access_ph && APB_REQ.pwrite && !hit_sel) |=> $stable(st_r.sel);
    endproperty
    a_nowrite: assert property (p_nowrite) else $error("stray write landed");

    c_wide:  cover property (@(posedge MCLK) run && PIN_ROLE.data_lane_31_16);
    c_read:  cover property (@(posedge MCLK) run && access_ph && !APB_REQ.pwrite && hit_sel);
    c_err:   cover property (@(posedge MCLK) run && access_ph && APB_RSP.pslverr);
    c_noadr: cover property (@(posedge MCLK) SRST && st_r.boot_sync2 == EFPS_BOOT_NOADR);

endmodule : efps_pin_select

// *** verif/test_efps_pin_select.sv ***
`timescale 1ns/10ps

module test_efps_pin_select;
    import efps_pkg::*;

    // writable bits and run ceiling
    localparam logic [31:0] WMASK = 32'h0FF3E9FC;
    localparam int          LIMIT = 4000;

    logic          MCLK;
    logic          SRST;
    logic          CE;
    efps_apb_req_s APB_REQ;
    efps_apb_rsp_s APB_RSP;
    logic [1:0]    BOOT_SELECT_PINS;
    efps_role_s    PIN_ROLE;
    int            miscompares;
    int            cmp_count;
    int            cycles;
    logic [31:0]   rd;
    logic          err;

    efps_pin_select efps_pin_select_i (
        .MCLK             (MCLK),
        .SRST             (SRST),
        .CE               (CE),
        .APB_REQ          (APB_REQ),
        .APB_RSP          (APB_RSP),
        .BOOT_SELECT_PINS (BOOT_SELECT_PINS),
        .PIN_ROLE         (PIN_ROLE)
    );

    // 25 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end

    // hang guard
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            $display("[FAIL] %0t run did not finish", $time);
            summarize();
        end
    end

    // verdict and end of run
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // single comparison point
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer; returns at the edge where pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       input logic [3:0] st);
        @(posedge MCLK);
        APB_REQ.psel    <= 1'b1;
        APB_REQ.penable <= 1'b0;
        APB_REQ.pwrite  <= wr;
        APB_REQ.paddr   <= a;
        APB_REQ.pwdata  <= wd;
        APB_REQ.pstrb   <= st;
        @(posedge MCLK);
        APB_REQ.penable <= 1'b1;
        do @(posedge MCLK); while (APB_RSP.pready !== 1'b1);
        rd = APB_RSP.prdata;
        err = APB_RSP.pslverr;
        APB_REQ.psel    <= 1'b0;
        APB_REQ.penable <= 1'b0;
    endtask : apb

    // role enables expected from a register value
    function automatic logic [42:0] exp_role(input logic [31:0] v);
        efps_role_s r;
        logic [1:0] b;
        int         nl[8];
        nl = '{0, 2, 4, 6, 10, 14, 18, 22};
        b = v[5:4];
        r = '0;
        r.debug_port = v[2];
        r.trace_port = v[3];
        r.data_lane_7_0 = (b != 2'h3);
        r.chip_select_0 = (b != 2'h3);
        r.output_enable = (b != 2'h3);
        r.byte_lane_strobe_0 = (b != 2'h3);
        r.data_lane_15_8 = (b == 2'h1) || (b == 2'h2);
        r.byte_lane_strobe_1 = (b == 2'h1) || (b == 2'h2);
        r.data_lane_31_16 = (b == 2'h2);
        r.byte_lane_strobe_2_3 = (b == 2'h2);
        r.analog_input_4 = v[21] && (b != 2'h2);
        r.analog_input_5 = v[22] && (b != 2'h2);
        r.analog_input_6 = v[6] && (b != 2'h2);
        r.analog_input_7 = v[7] && (b != 2'h2);
        r.write_enable = v[8];
        r.chip_select_1 = v[11];
        r.chip_select_2 = (v[15:14] == 2'h1);
        r.chip_select_3 = (v[17:16] == 2'h1);
        r.external_clock_output = v[13] && (v[27:25] != 3'h7);
        r.address_line_0 = v[23];
        r.address_line_1 = v[24];
        r.address_line_23_2 = 22'((23'h1 << nl[v[27:25]]) - 23'h1);
        return r;
    endfunction : exp_role

    // compare the role outputs in groups
    task automatic chk_role(input logic [31:0] v);
        logic [42:0] g;
        logic [42:0] e;
        g = PIN_ROLE;
        e = exp_role(v);
        chk(64'(g[42:41]), 64'(e[42:41]), "debug/trace");
        chk(64'(g[40:33]), 64'(e[40:33]), "bus roles");
        chk(64'(g[32:29]), 64'(e[32:29]), "analog");
        chk(64'(g[28:24]), 64'(e[28:24]), "strobes");
        chk(64'(g[23:0]), 64'(e[23:0]), "address");
    endtask : chk_role

    // reset image for each boot pattern, taken over a fresh reset
    task automatic t_reset();
        logic [31:0] img;
        for (int i = 0; i < 4; i++) begin
            @(posedge MCLK);
            BOOT_SELECT_PINS <= 2'(i);
            SRST <= 1'b1;
            repeat (4) @(posedge MCLK);
            SRST <= 1'b0;
            img = {4'h0, (i == 3) ? 3'h0 : 3'h7, 1'(i >> 1), (i == 0), 2'h3, 13'h0,
                   2'h3, 2'(i), 4'h0};
            apb(1'b0, EFPS_SEL_ADDR, 32'h0, 4'hF);
            chk(64'(rd), 64'(img), "reset value");
            chk_role(img);
            apb(1'b0, EFPS_STAT_ADDR, 32'h0, 4'hF);
            chk(64'(rd), 64'(i), "boot capture");
        end
        $display("test reset values done");
    endtask : t_reset

    // write, read back and decode a set of values and every address count
    task automatic t_table();
        logic [31:0] tab[4];
        logic [31:0] v;
        tab = '{32'h00000000, 32'hFFFFFFFF, 32'h0D6169EC, 32'h0270A0D0};
        for (int i = 0; i < 12; i++) begin
            v = (i < 4) ? tab[i] : ({4'h0, 3'(i - 4), 25'h0} | 32'h00002030);
            apb(1'b1, EFPS_SEL_ADDR, v, 4'hF);
            chk(64'(err), 64'h0, "write error");
            @(posedge MCLK);
            #1;
            chk_role(v & WMASK);
            apb(1'b0, EFPS_SEL_ADDR, 32'h0, 4'hF);
            chk(64'(rd), 64'(v & WMASK), "read back");
        end
        $display("test decode table done");
    endtask : t_table

    // byte strobes, unmapped place, status place, reserved code flag
    task automatic t_access();
        apb(1'b1, EFPS_SEL_ADDR, 32'h0, 4'hF);
        apb(1'b1, EFPS_SEL_ADDR, 32'hFFFFFFFF, 4'h2);
        apb(1'b0, EFPS_SEL_ADDR, 32'h0, 4'hF);
        chk(64'(rd), 64'h0000E900, "byte strobe");
        apb(1'b1, EFPS_SEL_ADDR + 32'h4, 32'hFFFFFFFF, 4'hF);
        chk(64'(err), 64'h1, "unmapped write");
        apb(1'b0, EFPS_SEL_ADDR + 32'h4, 32'h0, 4'hF);
        chk(64'({err, rd}), 64'h100000000, "unmapped read");
        apb(1'b1, EFPS_STAT_ADDR, 32'hFFFFFFFF, 4'hF);
        chk(64'(err), 64'h0, "status write");
        apb(1'b1, EFPS_SEL_ADDR, 32'h00100000, 4'hF);
        apb(1'b0, EFPS_SEL_ADDR, 32'h0, 4'hF);
        chk(64'(rd), 64'h00100000, "reserved code kept");
        chk_role(32'h00100000);
        apb(1'b0, EFPS_STAT_ADDR, 32'h0, 4'hF);
        chk(64'(rd), 64'h7, "status flag");
        $display("test access kinds done");
    endtask : t_access

    // main sequence
    initial begin
        SRST = 1'b1;
        CE = 1'b1;
        APB_REQ = '0;
        BOOT_SELECT_PINS = 2'h0;
        miscompares = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (4) @(posedge MCLK);
        SRST <= 1'b0;
        t_reset();
        t_table();
        t_access();
        summarize();
    end

endmodule : test_efps_pin_select
